// ---- rtl/asir_top.v ----
// Analog select, port readback and remappable input selector block
// Function
// - One analog-select bit per analog-capable pin
// - Port read returns zero on analog inputs
// - Analog modes use select one, direction input
// - Mapping writes ignored while lock bit set
// - Twenty-one input, sixteen output selector registers
// - Interrupt one selector bits 13-8, resets ones
// - Interrupt three selector bits 13-8, resets ones
// - Interrupt two selector bits 5-0, resets ones
// - Unimplemented mapping bits read zero
`timescale 1ns/1ps
`include "asir_regs.vh"
module asir_top
(
  input  wire                      clk,
  input  wire                      sys_rst,
  input  wire [`ASIR_AW-1:0]       s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`ASIR_AW-1:0]       s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire [`ASIR_NPINS-1:0]    pin_in,
  output reg  [`ASIR_NPINS-1:0]    pin_out,
  output reg  [`ASIR_NPINS-1:0]    pin_oe,
  output reg  [`ASIR_NPINS-1:0]    analog_en,
  input  wire [`ASIR_NRP-1:0]      remappable_pin,
  output reg                       external_interrupt_one,
  output reg                       external_interrupt_two,
  output reg                       external_interrupt_three
);

////////////////////////////////////////////////////////////////////////////
// Registers
reg  [`ASIR_NPINS-1:0] analog_select_control_q;
reg  [`ASIR_NPINS-1:0] pin_direction_bits_q;
reg  [`ASIR_NPINS-1:0] latch_q;
reg                    mapping_lock_bit_q;
reg  [15:0]            in_sel_q  [0:`ASIR_NIN_SEL-1];
reg  [15:0]            out_sel_q [0:`ASIR_NOUT_SEL-1];
wire [`ASIR_NPINS-1:0] pin_sync;
wire [`ASIR_NRP-1:0]   rp_sync;
wire [15:0]            ext_irq1_input_select;
wire [15:0]            ext_irq2_irq3_input_select;
wire [`ASIR_SEL_W-1:0] ext_irq1_pin_selector;
wire [`ASIR_SEL_W-1:0] ext_irq2_pin_selector;
wire [`ASIR_SEL_W-1:0] ext_irq3_pin_selector;

// Index of an input or output selector word, or -1 when unmapped
function integer in_index;
  input [`ASIR_AW-1:0] a;
  begin
    if (a >= `ASIR_ADDR_IN_BASE && a < `ASIR_ADDR_OUT_BASE &&
        ((a - `ASIR_ADDR_IN_BASE) >> 2) < `ASIR_NIN_SEL)
      in_index = (a - `ASIR_ADDR_IN_BASE) >> 2;
    else
      in_index = -1;
  end
endfunction

function integer out_index;
  input [`ASIR_AW-1:0] a;
  begin
    if (a >= `ASIR_ADDR_OUT_BASE && a < `ASIR_ADDR_MAP_END)
      out_index = (a - `ASIR_ADDR_OUT_BASE) >> 2;
    else
      out_index = -1;
  end
endfunction

function known_addr;
  input [`ASIR_AW-1:0] a;
  begin
    known_addr = (a[1:0] == 2'b00) &&
                 (a == `ASIR_ADDR_ANALOG_SELECT_CONTROL || a == `ASIR_ADDR_DIR ||
                  a == `ASIR_ADDR_PORT || a == `ASIR_ADDR_LAT ||
                  a == `ASIR_ADDR_LOCK || in_index(a) >= 0 ||
                  out_index(a) >= 0);
  end
endfunction

// Byte-lane merge of a write into a 16-bit register
function [15:0] merge;
  input [15:0] old;
  input [31:0] nw;
  input [1:0]  strb;
  begin
    merge = {strb[1] ? nw[15:8] : old[15:8],
             strb[0] ? nw[7:0]  : old[7:0]};
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers
asir_sync #(.W(`ASIR_NPINS)) u_pin_sync
(
  .clk     (clk),
  .sys_rst (sys_rst),
  .din     (pin_in),
  .dout    (pin_sync)
);

asir_sync #(.W(`ASIR_NRP)) u_rp_sync
(
  .clk     (clk),
  .sys_rst (sys_rst),
  .din     (remappable_pin),
  .dout    (rp_sync)
);

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path
reg                 aw_have_q;
reg                 w_have_q;
reg [`ASIR_AW-1:0]  aw_addr_q;
reg [31:0]          w_data_q;
reg [3:0]           w_strb_q;
wire                wr_go;
integer             wi;
integer             wo;
assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

always @*
begin
  wi = in_index(aw_addr_q);
  wo = out_index(aw_addr_q);
end

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    aw_have_q     <= 1'b0;
    w_have_q      <= 1'b0;
    aw_addr_q     <= {`ASIR_AW{1'b0}};
    w_data_q      <= 32'h00000000;
    w_strb_q      <= 4'h0;
    s_axi_awready <= 1'b0;
    s_axi_wready  <= 1'b0;
    s_axi_bvalid  <= 1'b0;
    s_axi_bresp   <= `ASIR_RESP_OKAY;
  end
  else
  begin
    s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
    s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    if (wr_go)
    begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(aw_addr_q) ? `ASIR_RESP_OKAY
                                            : `ASIR_RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// Register file
genvar g;
always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    analog_select_control_q <= `ASIR_ANALOG_SELECT_CONTROL_RST;
    pin_direction_bits_q    <= `ASIR_DIR_RST;
    latch_q                 <= 16'h0000;
    mapping_lock_bit_q      <= 1'b0;
  end
  else if (wr_go)
  begin
    case (aw_addr_q)
      `ASIR_ADDR_ANALOG_SELECT_CONTROL: analog_select_control_q <=
        merge(analog_select_control_q, w_data_q, w_strb_q[1:0]);
      `ASIR_ADDR_DIR: pin_direction_bits_q <=
        merge(pin_direction_bits_q, w_data_q, w_strb_q[1:0]);
      `ASIR_ADDR_LAT: latch_q <=
        merge(latch_q, w_data_q, w_strb_q[1:0]);
      `ASIR_ADDR_LOCK:
        if (w_strb_q[0])
          mapping_lock_bit_q <= w_data_q[`ASIR_LOCK_BIT];
      default: ;
    endcase
  end
end

generate
  for (g = 0; g < `ASIR_NIN_SEL; g = g + 1)
  begin : g_in
    always @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        // First word resets to ones in field only
        in_sel_q[g] <= (g == 0) ? `ASIR_IN_RST0 : `ASIR_IN_RST;
      else if (wr_go && wi == g && !mapping_lock_bit_q)
        in_sel_q[g] <= merge(in_sel_q[g], w_data_q, w_strb_q[1:0]) &
          ((g == 0) ? `ASIR_MASK_IN0 : `ASIR_MASK_MAP);
    end
  end
  for (g = 0; g < `ASIR_NOUT_SEL; g = g + 1)
  begin : g_out
    always @(posedge clk or posedge sys_rst)
    begin
      if (sys_rst)
        out_sel_q[g] <= `ASIR_OUT_RST;
      else if (wr_go && wo == g && !mapping_lock_bit_q)
        out_sel_q[g] <= merge(out_sel_q[g], w_data_q, w_strb_q[1:0]) &
          `ASIR_MASK_MAP;
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Port readback and pin drive
wire [`ASIR_NPINS-1:0] port_view;
assign port_view = pin_sync &
  ~(analog_select_control_q & pin_direction_bits_q);

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    pin_out   <= 16'h0000;
    pin_oe    <= 16'h0000;
    analog_en <= `ASIR_ANALOG_SELECT_CONTROL_RST;
  end
  else
  begin
    // Analog or digital function per pin
    analog_en <= analog_select_control_q;
    pin_out   <= latch_q;
    pin_oe    <= ~pin_direction_bits_q & ~analog_select_control_q;
  end
end

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path
integer ri;
integer ro;
reg [31:0] rd_d;
always @*
begin
  ri = in_index(s_axi_araddr);
  ro = out_index(s_axi_araddr);
  rd_d = 32'h00000000;
  case (s_axi_araddr)
    `ASIR_ADDR_ANALOG_SELECT_CONTROL: rd_d = {16'h0000, analog_select_control_q};
    `ASIR_ADDR_DIR:   rd_d = {16'h0000, pin_direction_bits_q};
    `ASIR_ADDR_PORT:  rd_d = {16'h0000, port_view};
    `ASIR_ADDR_LAT:   rd_d = {16'h0000, latch_q};
    `ASIR_ADDR_LOCK:  rd_d = {25'h0, mapping_lock_bit_q, 6'h00};
    default:
      if (ri >= 0)
        rd_d = {16'h0000, in_sel_q[ri]};
      else if (ro >= 0)
        rd_d = {16'h0000, out_sel_q[ro]};
  endcase
end

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= 32'h00000000;
    s_axi_rresp   <= `ASIR_RESP_OKAY;
  end
  else
  begin
    s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= known_addr(s_axi_araddr) ? `ASIR_RESP_OKAY
                                               : `ASIR_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// Interrupt input routing
assign ext_irq1_input_select      = in_sel_q[0];
assign ext_irq2_irq3_input_select = in_sel_q[1];
assign ext_irq1_pin_selector =
  ext_irq1_input_select[`ASIR_HI_LSB +: `ASIR_SEL_W];
assign ext_irq3_pin_selector =
  ext_irq2_irq3_input_select[`ASIR_HI_LSB +: `ASIR_SEL_W];
assign ext_irq2_pin_selector =
  ext_irq2_irq3_input_select[`ASIR_LO_LSB +: `ASIR_SEL_W];

// Pick pin n, out of range inactive
function pick;
  input [`ASIR_NRP-1:0]   rp;
  input [`ASIR_SEL_W-1:0] s;
  begin
    pick = (s < `ASIR_NRP) ? rp[s] : 1'b0;
  end
endfunction

always @(posedge clk or posedge sys_rst)
begin
  if (sys_rst)
  begin
    external_interrupt_one   <= 1'b0;
    external_interrupt_two   <= 1'b0;
    external_interrupt_three <= 1'b0;
  end
  else
  begin
    external_interrupt_one   <= pick(rp_sync, ext_irq1_pin_selector);
    external_interrupt_two   <= pick(rp_sync, ext_irq2_pin_selector);
    external_interrupt_three <= pick(rp_sync, ext_irq3_pin_selector);
  end
end

endmodule // asir_top

// ---- rtl/asir_regs.vh ----
// Register map, field layout and reset values of the pin select block
`ifndef ASIR_REGS_VH
`define ASIR_REGS_VH
`define ASIR_NPINS          16
`define ASIR_NRP            48
`define ASIR_NIN_SEL        21
`define ASIR_NOUT_SEL       16
`define ASIR_AW             8
// Byte addresses
`define ASIR_ADDR_ANALOG_SELECT_CONTROL     8'h00
`define ASIR_ADDR_DIR       8'h04
`define ASIR_ADDR_PORT      8'h08
`define ASIR_ADDR_LAT       8'h0c
`define ASIR_ADDR_LOCK      8'h10
`define ASIR_ADDR_IN_BASE   8'h20
`define ASIR_ADDR_OUT_BASE  8'h80
`define ASIR_ADDR_MAP_END   8'hc0
// Selector fields
`define ASIR_SEL_W          6
`define ASIR_HI_LSB         8
`define ASIR_LO_LSB         0
`define ASIR_SEL_RST        6'h3f
`define ASIR_MASK_IN0       16'h3f00
`define ASIR_MASK_MAP       16'h3f3f
`define ASIR_IN_RST0        16'h3f00
`define ASIR_IN_RST         16'h3f3f
`define ASIR_OUT_RST        16'h0000
`define ASIR_LOCK_BIT       6
`define ASIR_ANALOG_SELECT_CONTROL_RST      16'hffff
`define ASIR_DIR_RST        16'hffff
`define ASIR_RESP_OKAY      2'b00
`define ASIR_RESP_SLVERR    2'b10
`endif

// ---- rtl/asir_sync.v ----
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module asir_sync
#(
  parameter W = 16
)
(
  input  wire         clk,
  input  wire         sys_rst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Per bit, accept only when stages two and three agree
      dout <= (dout & ~(s2_q ^ s3_q) & ~(s2_q ^ dout)) |
              (s2_q & ~(s2_q ^ s3_q)) |
              (dout & (s2_q ^ s3_q));
    end
  end
endmodule // asir_sync

// ---- verification/asir_top_asserts.sv ----
// Bus handshake and pin configuration assertions
`timescale 1ns/1ps
module asir_top_asserts
(
  input wire        clk,
  input wire        sys_rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [15:0] pin_oe,
  input wire [15:0] analog_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_oe_not_analog: assert property (
    (pin_oe & analog_en) == 16'h0000) else $error("driven analog pin");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready not a pulse");
  a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready not a pulse");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_bresp_code: assert property (s_axi_bvalid |->
    s_axi_bresp inside {2'b00, 2'b10}) else $error("bad bresp");
endmodule // asir_top_asserts

// ---- verification/asir_top_tb.sv ----
// Self-checking bench for the pin select block
`timescale 1ns/1ps
module asir_top_tb;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'hf;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg  [15:0] pin_in = 16'h0000;
  reg  [47:0] rp = 48'h0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] pin_out, pin_oe, analog_en;
  wire        i1, i2, i3;
  integer     mismatches = 0;
  integer     samples_checked = 0;

  always #12.5 clk = ~clk;

  asir_top uut
  (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .analog_en(analog_en), .remappable_pin(rp),
    .external_interrupt_one(i1), .external_interrupt_two(i2),
    .external_interrupt_three(i3)
  );

  ////////////////////////////////////////////////////////////////////
  task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  end
  endtask

  task wr(input [7:0] a, input [31:0] d);
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, bresp});
    @(posedge clk);
  end
  endtask

  task rchk(input [7:0] a, input [31:0] e, input [1:0] er);
  begin
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge clk);
  end
  endtask

  ////////////////////////////////////////////////////////////////////
  task t_reset;
  begin
    rchk(8'h20, 32'h3f00, 2'b00);
    rchk(8'h24, 32'h3f3f, 2'b00);
    rchk(8'h70, 32'h3f3f, 2'b00);
    rchk(8'hbc, 32'h0000, 2'b00);
    rchk(8'h74, 32'h0000, 2'b10);
    rchk(8'hc0, 32'h0000, 2'b10);
    $display("reset test done");
  end
  endtask

  task t_bits;
  begin
    wr(8'h20, 32'hffffffff);
    rchk(8'h20, 32'h3f00, 2'b00);
    wr(8'h24, 32'hffffffff);
    rchk(8'h24, 32'h3f3f, 2'b00);
    wstrb <= 4'h2;
    wr(8'h24, 32'h00000000);
    wstrb <= 4'hf;
    rchk(8'h24, 32'h003f, 2'b00);
    $display("bits test done");
  end
  endtask

  task t_remap;
  begin
    wr(8'h24, 32'h2f05);
    wr(8'h20, 32'h0000);
    rp <= 48'h20;
    repeat (8) @(posedge clk);
    chk("irq1", 32'h0, {31'h0, i1});
    chk("irq2", 32'h1, {31'h0, i2});
    chk("irq3", 32'h0, {31'h0, i3});
    rp <= {48{1'b1}};
    repeat (8) @(posedge clk);
    chk("irq1", 32'h1, {31'h0, i1});
    chk("irq3", 32'h1, {31'h0, i3});
    wr(8'h24, 32'h3005);
    repeat (8) @(posedge clk);
    chk("irq3", 32'h0, {31'h0, i3});
    $display("remap test done");
  end
  endtask

  task t_lock;
  begin
    wr(8'h10, 32'h40);
    rchk(8'h10, 32'h40, 2'b00);
    wr(8'h24, 32'h0101);
    wr(8'h80, 32'hffff);
    rchk(8'h80, 32'h0000, 2'b00);
    rchk(8'h24, 32'h3005, 2'b00);
    wr(8'h10, 32'h00);
    wr(8'h24, 32'h0101);
    rchk(8'h24, 32'h0101, 2'b00);
    wr(8'h80, 32'hffff);
    rchk(8'h80, 32'h3f3f, 2'b00);
    $display("lock test done");
  end
  endtask

  task t_pins;
  begin
    wr(8'h00, 32'h000f);
    wr(8'h04, 32'h00f3);
    wr(8'h0c, 32'ha5a5);
    pin_in <= 16'hffff;
    repeat (10) @(posedge clk);
    chk("pin_oe", 32'hff00, {16'h0, pin_oe});
    chk("analog", 32'h000f, {16'h0, analog_en});
    chk("pin_out", 32'ha5a5, {16'h0, pin_out});
    rchk(8'h08, 32'hfffc, 2'b00);
    $display("pins test done");
  end
  endtask

  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_bits;
    t_remap;
    t_lock;
    t_pins;
    final_report;
  end

  initial
  begin
    #(25 * 5000);
    mismatches = mismatches + 1;
    final_report;
  end
endmodule // asir_top_tb

bind asir_top asir_top_asserts u_chk
(
  .clk(clk), .sys_rst(sys_rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_oe(pin_oe), .analog_en(analog_en)
);
